// ---- rtl/slrb_bank.sv ----
// Command-addressed supervising limit bank for a four-channel supply manager.
// Assumes a host link on its own clock and slowly changing sense words on pins.
// Operation
// - Full erase keeps device busy 400 ms
// - While busy, reject all but status
// - Status byte always readable, even while busy; writes to it rejected
// - Conversion allowed only above turn-on level
// - Below turn-off level, channels drop or sequence
// - Input overvoltage fault and warning limits
// - Input undervoltage warning and fault limits
// - Output format byte reads fixed 0x13
// - Per-channel servo target word
// - Commanded output never exceeds ceiling
// - Per-channel margin upper and lower setpoints
// - Output overvoltage fault and warning limits
// - Output undervoltage warning limit
// - Undervoltage fault limit drives turn-on timeout
// - Power good at or above assert level
// - Power good off at deassert level, or at undervoltage fault limit with GOOD_OFF_USES_UNDERVOLT_BIT set
// - Discharge threshold is target times coefficient
// - Ten-bit trim code, reset zero
`timescale 1ns/1ps
`include "slrb_defs.svh"
module slrb_bank #(
	parameter int PAGES = 4,
	parameter int TRIM_BITS = 10,
	parameter int ERASE_CYCLES = int'(longint'(`SLRB_ERASE_MS) * `SLRB_CLK_HZ / 1000),
	parameter int TOFF_CYCLES = 20,
	parameter int TON_MAX_CYCLES = 200
)(
	// Core clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Host link, on the link clock
	input wire logic LINK_CLK,
	input wire logic LNK_REQ,
	input wire logic LNK_WR,
	input wire logic [7:0] LNK_CMD,
	input wire logic [15:0] LNK_WDATA,
	output logic LNK_READY,
	output logic LNK_DONE,
	output logic LNK_NACK,
	output logic [15:0] LNK_RDATA,
	// Sense pins
	input wire logic [15:0] INPUT_SENSE_PIN,
	input wire logic [16*PAGES-1:0] OUT_SENSE,
	// Control pins
	input wire logic [PAGES-1:0] CHAN_ON_REQ,
	input wire logic [2*PAGES-1:0] MARGIN_SEL,
	input wire logic TRACK_EN,
	input wire logic GOOD_OFF_USES_UNDERVOLT_BIT,
	// Channel outputs
	output logic [PAGES-1:0] CHANNEL_ENABLE_OUTPUT,
	output logic [16*PAGES-1:0] SERVO_SETPOINT,
	output logic [TRIM_BITS*PAGES-1:0] TRIM_CODE,
	output logic [PAGES-1:0] POWER_GOOD,
	output logic [PAGES-1:0] DISCHARGED,
	output logic [PAGES-1:0] TON_FAULT,
	output logic [PAGES-1:0] OUT_OV_FAULT,
	output logic [PAGES-1:0] OUT_OV_WARN,
	output logic [PAGES-1:0] OUT_UV_WARN,
	output logic [PAGES-1:0] OUT_UV_FAULT,
	// Input supervisor and memory busy outputs
	output logic IN_OV_FAULT,
	output logic IN_OV_WARN,
	output logic IN_UV_WARN,
	output logic IN_UV_FAULT,
	output logic CONV_ON,
	output logic NVM_BUSY
);
	localparam int WORD_CYCLES = int'((longint'(`SLRB_WORD_PROG_NS) * `SLRB_CLK_HZ + 64'd999999999) / 64'd1000000000);
	localparam int NSLOT = 12;
	localparam logic [3:0] S_SERVO = 4'h0, S_CEIL = 4'h1, S_MHI = 4'h2, S_MLO = 4'h3, S_OOVF = 4'h4;
	localparam logic [3:0] S_OOVW = 4'h5, S_OUVW = 4'h6, S_OUVF = 4'h7, S_GON = 4'h8, S_GOFF = 4'h9;
	localparam logic [3:0] S_DCOEF = 4'hA, S_TRIM = 4'hB;
	localparam logic [2:0] G_ON = 3'h0, G_OFF = 3'h1, G_OVF = 3'h2, G_OVW = 3'h3, G_UVW = 3'h4, G_UVF = 3'h5;

	// Parameters the logic cannot serve
	if (PAGES < 1 || PAGES > 4 || TRIM_BITS < 1 || TRIM_BITS > 16 || ERASE_CYCLES < 1 || ERASE_CYCLES > 16777215
		|| TOFF_CYCLES < 1 || TOFF_CYCLES > 65535 || TON_MAX_CYCLES < 1 || TON_MAX_CYCLES > 65535)
	begin : g_bad
		$error("slrb_bank: unsupported parameter value");
	end

	// Paged command decode: bit 4 flags a hit
	function automatic logic [4:0] pg_slot(input logic [7:0] c);
		unique case (c)
			`SLRB_CMD_SERVO: pg_slot = {1'b1, S_SERVO};
			`SLRB_CMD_CEIL: pg_slot = {1'b1, S_CEIL};
			`SLRB_CMD_MHI: pg_slot = {1'b1, S_MHI};
			`SLRB_CMD_MLO: pg_slot = {1'b1, S_MLO};
			`SLRB_CMD_OOVF: pg_slot = {1'b1, S_OOVF};
			`SLRB_CMD_OOVW: pg_slot = {1'b1, S_OOVW};
			`SLRB_CMD_OUVW: pg_slot = {1'b1, S_OUVW};
			`SLRB_CMD_OUVF: pg_slot = {1'b1, S_OUVF};
			`SLRB_CMD_GON: pg_slot = {1'b1, S_GON};
			`SLRB_CMD_GOFF: pg_slot = {1'b1, S_GOFF};
			`SLRB_CMD_DCOEF: pg_slot = {1'b1, S_DCOEF};
			`SLRB_CMD_TRIM: pg_slot = {1'b1, S_TRIM};
			default: pg_slot = 5'h00;
		endcase
	endfunction

	// Global command decode: bit 3 flags a hit
	function automatic logic [3:0] gl_slot(input logic [7:0] c);
		unique case (c)
			`SLRB_CMD_IN_ON: gl_slot = {1'b1, G_ON};
			`SLRB_CMD_IN_OFF: gl_slot = {1'b1, G_OFF};
			`SLRB_CMD_IOVF: gl_slot = {1'b1, G_OVF};
			`SLRB_CMD_IOVW: gl_slot = {1'b1, G_OVW};
			`SLRB_CMD_IUVW: gl_slot = {1'b1, G_UVW};
			`SLRB_CMD_IUVF: gl_slot = {1'b1, G_UVF};
			default: gl_slot = 4'h0;
		endcase
	endfunction

	function automatic logic [15:0] pg_rst(input logic [3:0] s);
		unique case (s)
			S_SERVO: pg_rst = `SLRB_RST_SERVO;
			S_CEIL: pg_rst = `SLRB_RST_CEIL;
			S_MHI: pg_rst = `SLRB_RST_MHI;
			S_MLO: pg_rst = `SLRB_RST_MLO;
			S_OOVF: pg_rst = `SLRB_RST_OOVF;
			S_OOVW: pg_rst = `SLRB_RST_OOVW;
			S_OUVW: pg_rst = `SLRB_RST_OUVW;
			S_OUVF: pg_rst = `SLRB_RST_OUVF;
			S_GON: pg_rst = `SLRB_RST_GON;
			S_GOFF: pg_rst = `SLRB_RST_GOFF;
			S_DCOEF: pg_rst = `SLRB_RST_DCOEF;
			default: pg_rst = `SLRB_RST_TRIM;
		endcase
	endfunction

	function automatic logic [15:0] gl_rst(input logic [2:0] s);
		unique case (s)
			G_ON: gl_rst = `SLRB_RST_IN_ON;
			G_OFF: gl_rst = `SLRB_RST_IN_OFF;
			G_OVF: gl_rst = `SLRB_RST_IOVF;
			G_OVW: gl_rst = `SLRB_RST_IOVW;
			G_UVW: gl_rst = `SLRB_RST_IUVW;
			default: gl_rst = `SLRB_RST_IUVF;
		endcase
	endfunction

	// Linear value: signed mantissa times two to the exponent, scaled by 2^16
	function automatic logic signed [47:0] l11_val(input logic [15:0] w);
		logic signed [47:0] m;
		logic signed [6:0] sh;
		m = 48'(signed'(w[10:0]));
		sh = 7'(signed'(w[15:11])) + 7'sd16;
		if (sh >= 0)
			l11_val = m <<< sh;
		else
			l11_val = m >>> (-sh);
	endfunction

	// Off threshold in output units: target times linear coefficient
	function automatic logic signed [47:0] disch_thr(input logic [15:0] tgt, input logic [15:0] coef);
		logic signed [47:0] p;
		logic signed [6:0] sh;
		p = 48'(signed'({1'b0, tgt})) * 48'(signed'(coef[10:0]));
		sh = 7'(signed'(coef[15:11]));
		if (sh >= 0)
			disch_thr = p <<< sh;
		else
			disch_thr = p >>> (-sh);
	endfunction

	// Link domain reset, brought over from the core reset
	logic lrst_meta_ff, lrst_n_ff;
	always_ff @(posedge LINK_CLK)
	begin
		lrst_meta_ff <= RST_N;
		lrst_n_ff <= lrst_meta_ff;
	end

	// Link side: hold a request stable and toggle it across; busy until the answer returns
	logic lk_req_tgl_ff, lk_busy_ff, lk_wr_ff;
	logic [7:0] lk_cmd_ff;
	logic [15:0] lk_wdata_ff;
	logic lk_ack1_ff, lk_ack2_ff, lk_ack3_ff;
	logic ack_tgl_ff, nack_ff;
	logic [15:0] rdata_ff;
	always_ff @(posedge LINK_CLK)
	begin
		lk_ack1_ff <= ack_tgl_ff;
		lk_ack2_ff <= lk_ack1_ff;
		lk_ack3_ff <= lk_ack2_ff;
		if (!lrst_n_ff)
		begin
			lk_req_tgl_ff <= 1'b0;
			lk_busy_ff <= 1'b0;
			lk_wr_ff <= 1'b0;
			lk_cmd_ff <= 8'h00;
			lk_wdata_ff <= 16'h0000;
			LNK_READY <= 1'b0;
			LNK_DONE <= 1'b0;
			LNK_NACK <= 1'b0;
			LNK_RDATA <= 16'h0000;
		end
		else
		begin
			LNK_DONE <= 1'b0;
			if (lk_busy_ff && (lk_ack2_ff ^ lk_ack3_ff))
			begin
				// Answer words have stood still since the core toggled its ack
				lk_busy_ff <= 1'b0;
				LNK_READY <= 1'b1;
				LNK_DONE <= 1'b1;
				LNK_NACK <= nack_ff;
				LNK_RDATA <= rdata_ff;
			end
			else if (LNK_REQ && !lk_busy_ff && (lk_ack2_ff == lk_req_tgl_ff))
			begin
				lk_busy_ff <= 1'b1;
				LNK_READY <= 1'b0;
				lk_wr_ff <= LNK_WR;
				lk_cmd_ff <= LNK_CMD;
				lk_wdata_ff <= LNK_WDATA;
				lk_req_tgl_ff <= ~lk_req_tgl_ff;
			end
			else if (!lk_busy_ff)
				LNK_READY <= (lk_ack2_ff == lk_req_tgl_ff);
		end
	end

	// Core side request synchroniser
	logic req1_ff, req2_ff, req3_ff;
	always_ff @(posedge CLK)
	begin
		req1_ff <= lk_req_tgl_ff;
		req2_ff <= req1_ff;
		req3_ff <= req2_ff;
	end
	wire logic take = req2_ff ^ req3_ff;

	// Pin synchronisers
	logic [15:0] in_m1_ff, in_m2_ff;
	logic [16*PAGES-1:0] out_m1_ff, out_m2_ff;
	logic [PAGES-1:0] onr1_ff, onr2_ff;
	logic [2*PAGES-1:0] mrg1_ff, mrg2_ff;
	logic trk1_ff, trk2_ff, guv1_ff, guv2_ff;
	always_ff @(posedge CLK)
	begin
		in_m1_ff <= INPUT_SENSE_PIN;
		in_m2_ff <= in_m1_ff;
		out_m1_ff <= OUT_SENSE;
		out_m2_ff <= out_m1_ff;
		onr1_ff <= CHAN_ON_REQ;
		onr2_ff <= onr1_ff;
		mrg1_ff <= MARGIN_SEL;
		mrg2_ff <= mrg1_ff;
		trk1_ff <= TRACK_EN;
		trk2_ff <= trk1_ff;
		guv1_ff <= GOOD_OFF_USES_UNDERVOLT_BIT;
		guv2_ff <= guv1_ff;
	end

	// Storage: output words per page, input words shared
	logic [15:0] pg_ff [PAGES][NSLOT];
	logic [15:0] gl_ff [6];
	logic [1:0] page_ff;
	logic [7:0] erase_last_ff;
	logic busy_ff;
	logic [23:0] nvm_cnt_ff;
	slrb_pkg::slrb_nvm_t nvm_ff;
	wire logic [4:0] ps = pg_slot(lk_cmd_ff);
	wire logic [3:0] gs = gl_slot(lk_cmd_ff);

	// Request decode; only meaningful while take is high
	logic nxt_nack, pg_we, gl_we, page_we, erase_go, word_go;
	logic [15:0] nxt_rdata;
	always_comb
	begin
		nxt_nack = 1'b0;
		nxt_rdata = 16'h0000;
		pg_we = 1'b0;
		gl_we = 1'b0;
		page_we = 1'b0;
		erase_go = 1'b0;
		word_go = 1'b0;
		if (lk_cmd_ff == `SLRB_CMD_STATUS)
		begin
			// Status answers even while busy
			nxt_nack = lk_wr_ff;
			nxt_rdata[`SLRB_STAT_IDLE_BIT] = ~busy_ff;
		end
		else if (busy_ff)
			nxt_nack = 1'b1;
		else if (lk_cmd_ff == `SLRB_CMD_PAGE)
		begin
			if (lk_wr_ff)
			begin
				page_we = (lk_wdata_ff < 16'(PAGES));
				nxt_nack = ~page_we;
			end
			else
				nxt_rdata = {14'h0000, page_ff};
		end
		else if (lk_cmd_ff == `SLRB_CMD_OUT_FMT)
		begin
			nxt_nack = lk_wr_ff; // Read only
			nxt_rdata = {8'h00, `SLRB_OUT_FMT_VAL};
		end
		else if (ps[4])
		begin
			pg_we = lk_wr_ff;
			nxt_rdata = pg_ff[page_ff][ps[3:0]];
		end
		else if (gs[3])
		begin
			gl_we = lk_wr_ff;
			nxt_rdata = gl_ff[gs[2:0]];
		end
		else if (lk_cmd_ff == `SLRB_CMD_NVM_ERASE)
		begin
			erase_go = lk_wr_ff && (lk_wdata_ff[7:0] == `SLRB_ERASE_KEY);
			nxt_rdata = {8'h00, erase_last_ff};
		end
		else if (lk_cmd_ff == `SLRB_CMD_NVM_DATA)
			word_go = lk_wr_ff;
		else
			nxt_nack = 1'b1;
	end

	// Answer words and ack toggle back to the link
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			ack_tgl_ff <= 1'b0;
			nack_ff <= 1'b0;
			rdata_ff <= 16'h0000;
		end
		else if (take)
		begin
			ack_tgl_ff <= ~ack_tgl_ff;
			nack_ff <= nxt_nack;
			rdata_ff <= nxt_rdata;
		end
	end

	// Register writes; trim keeps only its code bits, the rest read as zero
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			for (int p = 0; p < PAGES; p++)
				for (int s = 0; s < NSLOT; s++)
					pg_ff[p][s] <= pg_rst(4'(s));
			for (int g = 0; g < 6; g++)
				gl_ff[g] <= gl_rst(3'(g));
			page_ff <= 2'h0;
			erase_last_ff <= 8'h00;
		end
		else if (take)
		begin
			if (pg_we)
				pg_ff[page_ff][ps[3:0]] <= (ps[3:0] == S_TRIM) ? (lk_wdata_ff & 16'((1 << TRIM_BITS) - 1))
					: lk_wdata_ff;
			if (gl_we)
				gl_ff[gs[2:0]] <= lk_wdata_ff;
			if (page_we)
				page_ff <= lk_wdata_ff[1:0];
			if (lk_cmd_ff == `SLRB_CMD_NVM_ERASE && lk_wr_ff && !busy_ff)
				erase_last_ff <= lk_wdata_ff[7:0];
		end
	end

	// Nonvolatile memory busy timing; the word time covers one programming cycle
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			nvm_ff <= slrb_pkg::SLRB_NVM_IDLE;
			nvm_cnt_ff <= 24'h000000;
			busy_ff <= 1'b0;
		end
		else
		begin
			unique case (nvm_ff)
				slrb_pkg::SLRB_NVM_IDLE:
				begin
					if (take && erase_go)
					begin
						nvm_ff <= slrb_pkg::SLRB_NVM_ERASE;
						nvm_cnt_ff <= 24'(ERASE_CYCLES - 1);
						busy_ff <= 1'b1;
					end
					else if (take && word_go)
					begin
						nvm_ff <= slrb_pkg::SLRB_NVM_WORD;
						nvm_cnt_ff <= 24'(WORD_CYCLES - 1);
						busy_ff <= 1'b1;
					end
				end
				slrb_pkg::SLRB_NVM_ERASE, slrb_pkg::SLRB_NVM_WORD:
				begin
					if (nvm_cnt_ff == 24'h000000)
					begin
						nvm_ff <= slrb_pkg::SLRB_NVM_IDLE;
						busy_ff <= 1'b0;
					end
					else
						nvm_cnt_ff <= nvm_cnt_ff - 24'h000001;
				end
			endcase
		end
	end
	assign NVM_BUSY = busy_ff;

	// Input supervisor: hysteresis gate for conversion and the four limit flags
	wire logic signed [47:0] in_val = l11_val(in_m2_ff);
	logic [15:0] toff_cnt_ff;
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			CONV_ON <= 1'b0;
			IN_OV_FAULT <= 1'b0;
			IN_OV_WARN <= 1'b0;
			IN_UV_WARN <= 1'b0;
			IN_UV_FAULT <= 1'b0;
			toff_cnt_ff <= 16'h0000;
		end
		else
		begin
			if (in_val > l11_val(gl_ff[G_ON]))
				CONV_ON <= 1'b1;
			else if (in_val < l11_val(gl_ff[G_OFF]))
				CONV_ON <= 1'b0;
			IN_OV_FAULT <= in_val > l11_val(gl_ff[G_OVF]);
			IN_OV_WARN <= in_val > l11_val(gl_ff[G_OVW]);
			IN_UV_WARN <= in_val < l11_val(gl_ff[G_UVW]);
			IN_UV_FAULT <= in_val < l11_val(gl_ff[G_UVF]);
			// Turn-off delay restarts whenever conversion is allowed again
			if (CONV_ON)
				toff_cnt_ff <= 16'(TOFF_CYCLES);
			else if (toff_cnt_ff != 16'h0000)
				toff_cnt_ff <= toff_cnt_ff - 16'h0001;
		end
	end
	wire logic off_now = !CONV_ON && (trk2_ff || toff_cnt_ff == 16'h0000);

	// Output channels: setpoint, supervision, power good, enable and turn-on timeout
	logic [15:0] ton_cnt_ff [PAGES];
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			CHANNEL_ENABLE_OUTPUT <= '0;
			SERVO_SETPOINT <= '0;
			TRIM_CODE <= '0;
			POWER_GOOD <= '0;
			DISCHARGED <= '0;
			TON_FAULT <= '0;
			OUT_OV_FAULT <= '0;
			OUT_OV_WARN <= '0;
			OUT_UV_WARN <= '0;
			OUT_UV_FAULT <= '0;
			for (int i = 0; i < PAGES; i++)
				ton_cnt_ff[i] <= 16'h0000;
		end
		else
		begin
			for (int i = 0; i < PAGES; i++)
			begin
				automatic logic [15:0] v = out_m2_ff[16*i +: 16];
				automatic logic [15:0] tgt = mrg2_ff[2*i +: 2] == 2'b01 ? pg_ff[i][S_MHI]
					: mrg2_ff[2*i +: 2] == 2'b10 ? pg_ff[i][S_MLO] : pg_ff[i][S_SERVO];
				automatic logic dis = 48'(signed'({1'b0, v})) < disch_thr(pg_ff[i][S_SERVO], pg_ff[i][S_DCOEF]);
				SERVO_SETPOINT[16*i +: 16] <= (tgt > pg_ff[i][S_CEIL]) ? pg_ff[i][S_CEIL] : tgt;
				TRIM_CODE[TRIM_BITS*i +: TRIM_BITS] <= pg_ff[i][S_TRIM][TRIM_BITS-1:0];
				DISCHARGED[i] <= dis;
				OUT_OV_FAULT[i] <= v > pg_ff[i][S_OOVF];
				OUT_OV_WARN[i] <= v > pg_ff[i][S_OOVW];
				OUT_UV_WARN[i] <= v < pg_ff[i][S_OUVW];
				OUT_UV_FAULT[i] <= v < pg_ff[i][S_OUVF];
				if (v >= pg_ff[i][S_GON])
					POWER_GOOD[i] <= 1'b1;
				else if (guv2_ff ? (v <= pg_ff[i][S_OUVF]) : (v <= pg_ff[i][S_GOFF]))
					POWER_GOOD[i] <= 1'b0;
				// A channel stays off until its output has decayed below the off threshold
				if (!onr2_ff[i] || (CHANNEL_ENABLE_OUTPUT[i] && off_now))
					CHANNEL_ENABLE_OUTPUT[i] <= 1'b0;
				else if (!CHANNEL_ENABLE_OUTPUT[i] && CONV_ON && dis)
					CHANNEL_ENABLE_OUTPUT[i] <= 1'b1;
				if (!CHANNEL_ENABLE_OUTPUT[i])
				begin
					ton_cnt_ff[i] <= 16'h0000;
					TON_FAULT[i] <= 1'b0;
				end
				else if (ton_cnt_ff[i] != 16'(TON_MAX_CYCLES))
					ton_cnt_ff[i] <= ton_cnt_ff[i] + 16'h0001;
				else if (v <= pg_ff[i][S_OUVF])
					TON_FAULT[i] <= 1'b1;
			end
		end
	end

	// Checks
	chk_busy_reject: assert property (@(posedge CLK) disable iff (!RST_N)
		take && busy_ff && lk_cmd_ff != `SLRB_CMD_STATUS |=> nack_ff)
		else $error("command taken while busy was not rejected");
	chk_status_live: assert property (@(posedge CLK) disable iff (!RST_N)
		take && !lk_wr_ff && lk_cmd_ff == `SLRB_CMD_STATUS |=> !nack_ff && rdata_ff[`SLRB_STAT_IDLE_BIT] == !$past(busy_ff))
		else $error("status read rejected or wrong busy bit");
	chk_erase_busy: assert property (@(posedge CLK) disable iff (!RST_N)
		take && erase_go && !busy_ff |=> busy_ff && nvm_cnt_ff == 24'(ERASE_CYCLES - 1))
		else $error("erase did not start full busy interval");
	chk_format_fixed: assert property (@(posedge CLK) disable iff (!RST_N)
		take && !busy_ff && lk_cmd_ff == `SLRB_CMD_OUT_FMT |=> rdata_ff == {8'h00, `SLRB_OUT_FMT_VAL}
		&& nack_ff == $past(lk_wr_ff))
		else $error("format byte wrong");
	chk_ceiling_cap: assert property (@(posedge CLK) disable iff (!RST_N)
		$past(RST_N) |-> SERVO_SETPOINT[15:0] <= $past(pg_ff[0][S_CEIL]))
		else $error("setpoint above ceiling");
	chk_conv_gate: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(CONV_ON) |-> $past(in_val > l11_val(gl_ff[G_ON])))
		else $error("conversion allowed below turn-on level");
	chk_good_on: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(POWER_GOOD[0]) |-> $past(out_m2_ff[15:0] >= pg_ff[0][S_GON]))
		else $error("power good rose below assert level");
	chk_track_drop: assert property (@(posedge CLK) disable iff (!RST_N)
		!CONV_ON && trk2_ff && CHANNEL_ENABLE_OUTPUT[0] |=> !CHANNEL_ENABLE_OUTPUT[0])
		else $error("tracked channel not dropped at once");
	chk_trim_upper: assert property (@(posedge CLK) disable iff (!RST_N)
		take && !lk_wr_ff && lk_cmd_ff == `SLRB_CMD_TRIM && !busy_ff |=> rdata_ff[15:TRIM_BITS] == '0)
		else $error("trim reserved bits not zero");
endmodule

// ---- shared/slrb_defs.svh ----
// Constants of the supply limit register bank: command codes, reset values and timing.
// Assumes a 20 MHz core clock; included by bare name wherever needed.
`ifndef SLRB_DEFS_SVH
`define SLRB_DEFS_SVH
`define SLRB_CMD_PAGE 8'h00
`define SLRB_CMD_OUT_FMT 8'h20
`define SLRB_CMD_SERVO 8'h21
`define SLRB_CMD_CEIL 8'h24
`define SLRB_CMD_MHI 8'h25
`define SLRB_CMD_MLO 8'h26
`define SLRB_CMD_IN_ON 8'h35
`define SLRB_CMD_IN_OFF 8'h36
`define SLRB_CMD_OOVF 8'h40
`define SLRB_CMD_OOVW 8'h42
`define SLRB_CMD_OUVW 8'h43
`define SLRB_CMD_OUVF 8'h44
`define SLRB_CMD_IOVF 8'h55
`define SLRB_CMD_IOVW 8'h57
`define SLRB_CMD_IUVW 8'h58
`define SLRB_CMD_IUVF 8'h59
`define SLRB_CMD_GON 8'h5E
`define SLRB_CMD_GOFF 8'h5F
`define SLRB_CMD_TRIM 8'hE0
`define SLRB_CMD_DCOEF 8'hE9
`define SLRB_CMD_STATUS 8'hEF
`define SLRB_CMD_NVM_ERASE 8'hBE
`define SLRB_CMD_NVM_DATA 8'hBF
`define SLRB_OUT_FMT_VAL 8'h13
`define SLRB_RST_SERVO 16'h2000
`define SLRB_RST_CEIL 16'h8000
`define SLRB_RST_MHI 16'h219A
`define SLRB_RST_MLO 16'h1E66
`define SLRB_RST_OOVF 16'h2333
`define SLRB_RST_OOVW 16'h2266
`define SLRB_RST_OUVW 16'h1D9A
`define SLRB_RST_OUVF 16'h1CCD
`define SLRB_RST_GON 16'h1EB8
`define SLRB_RST_GOFF 16'h1E14
`define SLRB_RST_DCOEF 16'hC200
`define SLRB_RST_TRIM 16'h0000
`define SLRB_RST_IN_ON 16'hD280
`define SLRB_RST_IN_OFF 16'hD240
`define SLRB_RST_IOVF 16'hD3C0
`define SLRB_RST_IOVW 16'hD380
`define SLRB_RST_IUVW 16'h8000
`define SLRB_RST_IUVF 16'h8000
`define SLRB_ERASE_KEY 8'h2B
`define SLRB_STAT_IDLE_BIT 6
`define SLRB_CLK_HZ 20000000
`define SLRB_WORD_PROG_NS 170000
`define SLRB_ERASE_MS 400
`endif

// ---- shared/slrb_pkg.sv ----
// Types of the supply limit register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package slrb_pkg;
	// Nonvolatile memory activity
	typedef enum {SLRB_NVM_IDLE, SLRB_NVM_ERASE, SLRB_NVM_WORD} slrb_nvm_t;
endpackage

// ---- verification/slrb_host_model.sv ----
// Host controller model for the command link of the limit bank.
// Assumes the bank takes a request on a link edge with ready high and answers with a done pulse.
`timescale 1ns/1ps
module slrb_host_model (
	// Link clock and answers
	input wire logic link_clk,
	input wire logic lnk_ready,
	input wire logic lnk_done,
	input wire logic lnk_nack,
	input wire logic [15:0] lnk_rdata,
	// Requests
	output logic lnk_req,
	output logic lnk_wr,
	output logic [7:0] lnk_cmd,
	output logic [15:0] lnk_wdata
);
	// Idle lines at time zero
	initial
	begin
		lnk_req = 1'b0;
		lnk_wr = 1'b0;
		lnk_cmd = 8'h00;
		lnk_wdata = 16'h0000;
	end

	// One transfer; a missing answer returns unknown so the caller flags it
	task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] wd, output logic nk,
		output logic [15:0] rd);
		int n;
		n = 0;
		@(posedge link_clk);
		while (lnk_ready !== 1'b1 && n < 100)
		begin
			@(posedge link_clk);
			n++;
		end
		#1;
		lnk_req = 1'b1;
		lnk_wr = wr;
		lnk_cmd = cmd;
		lnk_wdata = wd;
		@(posedge link_clk);
		#1;
		lnk_req = 1'b0;
		lnk_cmd = ~cmd; // Released command and data lines never keep the old value
		lnk_wdata = ~wd;
		n = 0;
		@(posedge link_clk);
		while (lnk_done !== 1'b1 && n < 40)
		begin
			@(posedge link_clk);
			n++;
		end
		nk = (n < 40) ? lnk_nack : 1'bx;
		rd = (n < 40) ? lnk_rdata : 16'hxxxx;
	endtask

	// Poll the status byte instead of trusting a fixed delay
	task automatic wait_idle(output logic ok);
		logic nk;
		logic [15:0] rd;
		ok = 1'b0;
		for (int n = 0; n < 3000 && !ok; n++)
		begin
			xfer(1'b0, 8'hEF, 16'h0000, nk, rd);
			ok = (rd[6] === 1'b1);
		end
	endtask

	// Word write, next one held back until programming has ended
	task automatic nvm_word(input logic [15:0] wd, output logic nk, output logic ok);
		logic [15:0] rd;
		xfer(1'b1, 8'hBF, wd, nk, rd);
		wait_idle(ok);
	endtask
endmodule

// ---- verification/supply_limit_register_bank_tb_top.sv ----
// Self-checking bench for the limit bank, host model on the link side.
// Assumes short erase and turn-on timeout counts set at the instance.
`timescale 1ns/1ps
module supply_limit_register_bank_tb_top;
	// Stimulus and observed wires
	logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, trk = 1'b1, gou = 1'b0, conv_e = 1'b0, pg_e = 1'b0;
	logic req, wr, rdy, done, nack, nk, ok, conv, busy, iovf, iovw, iuvw, iuvf;
	logic [7:0] cmd, msel = 8'h00;
	logic [15:0] wd, rdata, rd, rv, vin = 16'h0000;
	logic [63:0] vout = 64'h0, sp;
	logic [3:0] chon = 4'h0, en, pg, dis, ton, oovf, oovw, ouvw, ouvf;
	logic [39:0] trim;
	int fails = 0, cmp_count = 0, cyc = 0, bc = 0, seed = 94;
	logic [7:0] cmds [19] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h35, 8'h36, 8'h40, 8'h42, 8'h43, 8'h44,
		8'h55, 8'h57, 8'h58, 8'h59, 8'h5E, 8'h5F, 8'hE0, 8'hE9};
	logic [15:0] rstv [19] = '{16'h0013, 16'h2000, 16'h8000, 16'h219A, 16'h1E66, 16'hD280, 16'hD240, 16'h2333,
		16'h2266, 16'h1D9A, 16'h1CCD, 16'hD3C0, 16'hD380, 16'h8000, 16'h8000, 16'h1EB8, 16'h1E14, 16'h0000, 16'hC200};
	logic [15:0] vs [9] = '{16'h1EB8, 16'h1E50, 16'h1E14, 16'h1EB8, 16'h1E00, 16'h1CCD, 16'h2300, 16'h2400, 16'h5000};
	logic [15:0] ev [19][4];

	slrb_bank #(.ERASE_CYCLES(50), .TON_MAX_CYCLES(30)) dut_u (.CLK(clk), .RST_N(rst_n), .LINK_CLK(lclk),
		.LNK_REQ(req), .LNK_WR(wr), .LNK_CMD(cmd), .LNK_WDATA(wd), .LNK_READY(rdy), .LNK_DONE(done),
		.LNK_NACK(nack), .LNK_RDATA(rdata), .INPUT_SENSE_PIN(vin), .OUT_SENSE(vout), .CHAN_ON_REQ(chon),
		.MARGIN_SEL(msel), .TRACK_EN(trk), .GOOD_OFF_USES_UNDERVOLT_BIT(gou), .CHANNEL_ENABLE_OUTPUT(en),
		.SERVO_SETPOINT(sp), .TRIM_CODE(trim), .POWER_GOOD(pg), .DISCHARGED(dis), .TON_FAULT(ton),
		.OUT_OV_FAULT(oovf), .OUT_OV_WARN(oovw), .OUT_UV_WARN(ouvw), .OUT_UV_FAULT(ouvf), .IN_OV_FAULT(iovf),
		.IN_OV_WARN(iovw), .IN_UV_WARN(iuvw), .IN_UV_FAULT(iuvf), .CONV_ON(conv), .NVM_BUSY(busy));
	slrb_host_model host_u (.link_clk(lclk), .lnk_ready(rdy), .lnk_done(done), .lnk_nack(nack),
		.lnk_rdata(rdata), .lnk_req(req), .lnk_wr(wr), .lnk_cmd(cmd), .lnk_wdata(wd));

	// Core clock and link clock; rising edges of the two never coincide
	always #25 clk = ~clk;
	always #7.5 lclk = ~lclk;

	// Busy cycle count and hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (busy === 1'b1)
			bc++;
		if (cyc == 20000)
		begin
			fails++;
			final_report();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// Linear-11 value, compared by magnitude
	function automatic real l11(input logic [15:0] x);
		return $itor($signed(x[10:0])) * (2.0 ** $signed(x[15:11]));
	endfunction

	// Input step; conversion follows the hysteresis of the two levels
	task automatic vin_step(input logic [15:0] v);
		real m;
		vin = v;
		tick(6);
		m = l11(v);
		if (m > l11(16'hD280)) conv_e = 1'b1;
		else if (m < l11(16'hD240)) conv_e = 1'b0;
		chk({11'h000, conv, iovf, iovw, iuvw, iuvf}, {11'h000, conv_e, m > l11(16'hD3C0), m > l11(16'hD380),
			m < l11(16'h8000), m < l11(16'h8000)});
	endtask

	initial
	begin
		tick(6);
		rst_n = 1'b1;
		for (int i = 0; i < 19; i++)
		begin
			host_u.xfer(1'b0, cmds[i], 16'h0000, nk, rd);
			chk(rd, rstv[i]);
		end
		host_u.xfer(1'b1, 8'h20, 16'h00AA, nk, rd);
		chk({15'h0000, nk}, 16'h0001);
		// Erase: servo read refused, status still answered while busy
		bc = 0;
		host_u.xfer(1'b1, 8'hBE, 16'h002B, nk, rd);
		host_u.xfer(1'b0, 8'h21, 16'h0000, nk, rd);
		chk({15'h0000, nk}, 16'h0001);
		host_u.xfer(1'b0, 8'hEF, 16'h0000, nk, rd);
		chk({nk, rd[14:0]}, 16'h0000);
		host_u.wait_idle(ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(16'(bc), 16'h0032);
		host_u.xfer(1'b0, 8'hEF, 16'h0000, nk, rd);
		chk({nk, rd[14:0]}, 16'h0040);
		// Corner codes: status write, page out of range, erase byte readback
		host_u.xfer(1'b1, 8'hEF, 16'h0000, nk, rd);
		chk({15'h0000, nk}, 16'h0001);
		host_u.xfer(1'b1, 8'h00, 16'h0004, nk, rd);
		chk({15'h0000, nk}, 16'h0001);
		host_u.xfer(1'b0, 8'hBE, 16'h0000, nk, rd);
		chk({nk, rd[14:0]}, 16'h002B);
		bc = 0;
		host_u.nvm_word(16'h1234, nk, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(16'(bc), 16'h0D48);
		// Channel enable against input levels
		tick(1);
		chon = 4'h1;
		vin_step(16'hD2C0);
		tick(4);
		chk({15'h0000, en[0]}, 16'h0001);
		vin_step(16'hD260);
		vin_step(16'hD3A0);
		vin_step(16'hD3D0);
		tick(35);
		chk({15'h0000, ton[0]}, 16'h0001);
		vin_step(16'hD200);
		chk({15'h0000, en[0]}, 16'h0000);
		trk = 1'b0;
		vin_step(16'hD2C0);
		tick(4);
		// Output limits, power good and discharge on channel 0
		for (int i = 0; i < 9; i++)
		begin
			gou = (i == 4 || i == 5);
			vout[15:0] = vs[i];
			tick(6);
			if (vs[i] >= 16'h1EB8) pg_e = 1'b1;
			else if (gou ? vs[i] <= 16'h1CCD : vs[i] <= 16'h1E14) pg_e = 1'b0;
			chk({10'h000, pg[0], dis[0], oovf[0], oovw[0], ouvw[0], ouvf[0]}, {10'h000, pg_e, vs[i] < 16'h4000,
				vs[i] > 16'h2333, vs[i] > 16'h2266, vs[i] < 16'h1D9A, vs[i] < 16'h1CCD});
		end
		// Margin selection clamped by the ceiling
		host_u.xfer(1'b1, 8'h24, 16'h2100, nk, rd);
		for (int m = 0; m < 4; m++)
		begin
			msel[1:0] = 2'(m);
			tick(6);
			chk(sp[15:0], (m == 1) ? 16'h2100 : (m == 2) ? 16'h1E66 : 16'h2000);
		end
		vin_step(16'hD200);
		chk({15'h0000, en[0]}, 16'h0001);
		tick(25);
		chk({15'h0000, en[0]}, 16'h0000);
		// Random words per page, global words shared
		for (int p = 0; p < 4; p++)
		begin
			host_u.xfer(1'b1, 8'h00, 16'(p), nk, rd);
			for (int i = 1; i < 19; i++)
			begin
				rv = 16'($random(seed));
				ev[i][p] = (i == 17) ? {6'h00, rv[9:0]} : rv;
				host_u.xfer(1'b1, cmds[i], rv, nk, rd);
			end
		end
		for (int p = 0; p < 4; p++)
		begin
			host_u.xfer(1'b1, 8'h00, 16'(p), nk, rd);
			for (int i = 1; i < 19; i++)
			begin
				host_u.xfer(1'b0, cmds[i], 16'h0000, nk, rd);
				chk(rd, ((i > 4 && i < 7) || (i > 10 && i < 15)) ? ev[i][3] : ev[i][p]);
			end
			chk({6'h00, trim[10*p+:10]}, ev[17][p]);
			chk(sp[16*p+:16], (ev[1][p] > ev[2][p]) ? ev[2][p] : ev[1][p]);
		end
		final_report();
	end
endmodule
